// *** hdl/bier_map.svh ***
// register offsets, field positions, reset values and masks of the interrupt enable and routing block
// assumes inclusion by the top module only
`ifndef BIER_MAP_SVH
`define BIER_MAP_SVH

`define BIER_OFF_STATUS 12'h600
`define BIER_OFF_ENABLE 12'h604
`define BIER_OFF_ROUTE 12'h608
`define BIER_OFF_SOFT2 12'h60c
`define BIER_OFF_SOURCE 12'h610

`define BIER_ENABLE_RST 32'h0000_0000
`define BIER_ROUTE_RST 32'h0010_2000
`define BIER_STATUS_RST 32'h0000_0000
`define BIER_ENABLE_WMASK 32'hffff_df00
`define BIER_ROUTE_WMASK 32'hff0f_8f0f
`define BIER_ROUTE_RO_ONE 32'h0010_2000
`define BIER_STATUS_W1C 32'hffff_d00f
`define BIER_LEVEL_SRC 32'h0000_2f00
`define BIER_SOFT_ALWAYS 32'h0000_000f

`define BIER_BIT_OPNE 13
`define BIER_BIT_IPN 12
`define BIER_BIT_SI1 1
`define BIER_BIT_SI0 0
`define BIER_BIT_SI3 3
`define BIER_BIT_SI2 2

`define BIER_RESP_OKAY 2'h0
`define BIER_RESP_SLVERR 2'h2

`endif

// *** hdl/bier_pkg.sv ***
// types shared by the interrupt enable and routing block
// assumes bier_map.svh holds every number
package bier_pkg;
   typedef logic [31:0] bier_word_t;
   typedef struct packed {
      logic [11:0] addr;
      bier_word_t data;
      logic [3:0] strb;
   } bier_wreq_s;
   typedef enum logic [1:0] {BIER_W_IDLE, BIER_W_RESP} bier_wstate_e;
   typedef enum logic [1:0] {BIER_R_IDLE, BIER_R_DATA} bier_rstate_e;
endpackage

// *** hdl/bier_top.sv ***
// interrupt enable, routing and status block with an AXI4-Lite register slave
// assumes source events are one-cycle pulses or levels synchronous to I_SYS_CLK
//
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "bier_map.svh"

// Behaviour
// (R1) separate enables for both error-log interrupts
// (R2) enable for master data parity interrupt
// (R3) enable for config status-bit interrupt
// (R4) enables for DMA local and PCI errors
// (R5) enables for DMA reset and done
// (R6) PCI interrupt input to local gated
// (R7) PCI parity error to local gated
// (R8) PCI system error to local gated
// (R9) local interrupt input to PCI gated
// (R10) four mailbox interrupt enables
// (R11) enable for local data parity interrupt
// (R12) enable for power state change interrupt
// (R13) post-list nonempty enable mirrors messaging mask, read-only
// (R14) writable enable for inbound new entry
// (R15) writable enable for inbound free empty
// (R16) writable enable for outbound free empty
// (R17) writable enable for inbound post full
// (R18) writable enable for outbound free full
// (R19) writing one sets soft interrupt 1, reads 0
// (R20) writing one sets soft interrupt 0, reads 0
// (R21) route register layout mirrors enable layout
// (R22) enable register at 0x604, status bit positions
// (R23) status stays set until written one; level bits 8-11 and 13 follow their input, bits 4-7 ignore a write of one
// (R24) route bit 0 local, 1 PCI
// (R25) disabled source drives neither output
// (R26) writable enables clear on reset
// (R27) output high while enabled pending routed source
module bier_top (
   // clock and reset
   input wire logic I_SYS_CLK,
   input wire logic I_SRST,
   // axi4-lite write address and data
   input wire logic [11:0] I_AWADDR,
   input wire logic I_AWVALID,
   output logic O_AWREADY,
   input wire logic [31:0] I_WDATA,
   input wire logic [3:0] I_WSTRB,
   input wire logic I_WVALID,
   output logic O_WREADY,
   // axi4-lite write response
   output logic [1:0] O_BRESP,
   output logic O_BVALID,
   input wire logic I_BREADY,
   // axi4-lite read
   input wire logic [11:0] I_ARADDR,
   input wire logic I_ARVALID,
   output logic O_ARREADY,
   output logic [31:0] O_RDATA,
   output logic [1:0] O_RRESP,
   output logic O_RVALID,
   input wire logic I_RREADY,
   // interrupt sources, bit positions as in the status register
   input wire logic [31:0] I_SRC_EVENT,
   input wire logic I_OUTBOUND_POST_IRQ_MASK,
   // interrupt outputs, active high
   output logic O_LOCAL_IRQ,
   output logic O_PCI_IRQ
);

   // =====================================================
   // state
   bier_pkg::bier_word_t enable;
   bier_pkg::bier_word_t route;
   bier_pkg::bier_word_t status;
   bier_pkg::bier_wreq_s wreq;
   logic aw_held;
   logic w_held;
   bier_pkg::bier_wstate_e wstate;
   bier_pkg::bier_rstate_e rstate;
   logic [1:0] bresp;
   logic [31:0] rdata;
   logic [1:0] rresp;

   // =====================================================
   // write channel acceptance, either order
   wire logic w_idle = (wstate == bier_pkg::BIER_W_IDLE);
   wire logic aw_take = w_idle && !aw_held && I_AWVALID;
   wire logic w_take = w_idle && !w_held && I_WVALID;
   wire logic aw_have = aw_held || aw_take;
   wire logic w_have = w_held || w_take;
   wire logic wr_fire = w_idle && aw_have && w_have;
   wire logic [11:0] wr_addr = aw_held ? wreq.addr : I_AWADDR;
   wire logic [31:0] wr_data = w_held ? wreq.data : I_WDATA;
   wire logic [3:0] wr_strb = w_held ? wreq.strb : I_WSTRB;
   wire logic [31:0] wr_bmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
   wire logic [31:0] wr_bits = wr_data & wr_bmask;
   wire logic [11:0] wr_word = {wr_addr[11:2], 2'h0};
   wire logic hit_en_w = wr_fire && (wr_word == `BIER_OFF_ENABLE);
   wire logic hit_rt_w = wr_fire && (wr_word == `BIER_OFF_ROUTE);
   wire logic hit_st_w = wr_fire && (wr_word == `BIER_OFF_STATUS);
   wire logic hit_s2_w = wr_fire && (wr_word == `BIER_OFF_SOFT2);
   wire logic hit_src_w = wr_fire && (wr_word == `BIER_OFF_SOURCE);
   wire logic wr_mapped = hit_en_w || hit_rt_w || hit_st_w || hit_s2_w || hit_src_w;

   assign O_AWREADY = w_idle && !aw_held;
   assign O_WREADY = w_idle && !w_held;
   assign O_BVALID = (wstate == bier_pkg::BIER_W_RESP);
   assign O_BRESP = bresp;

   // =====================================================
   // enable register: writable bits only, opne bit mirrors the messaging mask
   wire logic [31:0] next_enable_w = (enable & ~(wr_bmask & `BIER_ENABLE_WMASK))
                                   | (wr_bits & `BIER_ENABLE_WMASK); // R1 R2 R3 R4 R5 R10 R11 R12
   wire logic [31:0] enable_view = (enable & `BIER_ENABLE_WMASK)
                                 | ({31'h0, I_OUTBOUND_POST_IRQ_MASK} << `BIER_BIT_OPNE); // R13
   // soft interrupts have no enable of their own, so they are always forwarded
   wire logic [31:0] enable_eff = enable_view | `BIER_SOFT_ALWAYS;
   // trigger bits: write one sets soft status, never stored
   wire logic [31:0] soft_set = ({30'h0, hit_en_w & wr_bits[`BIER_BIT_SI1], 1'h0}) // R19
                              | ({31'h0, hit_en_w & wr_bits[`BIER_BIT_SI0]}) // R20
                              | ({28'h0, hit_s2_w & wr_bits[`BIER_BIT_SI3], 3'h0})
                              | ({29'h0, hit_s2_w & wr_bits[`BIER_BIT_SI2], 2'h0});
   wire logic [31:0] next_route_w = (route & ~(wr_bmask & `BIER_ROUTE_WMASK))
                                  | (wr_bits & `BIER_ROUTE_WMASK) | `BIER_ROUTE_RO_ONE; // R21

   // =====================================================
   // status: latched sources are sticky, level sources follow their input
   wire logic [31:0] evt_latch = I_SRC_EVENT & ~`BIER_LEVEL_SRC;
   // new-entry status only latches while its enable is set
   wire logic [31:0] evt_gate = evt_latch & ~({31'h0, ~enable[`BIER_BIT_IPN]} << `BIER_BIT_IPN);
   wire logic [31:0] st_clear = hit_st_w ? (wr_bits & `BIER_STATUS_W1C) : 32'h0;
   wire logic [31:0] next_status = ((status & ~st_clear) | evt_gate | soft_set) & ~`BIER_LEVEL_SRC; // R23
   wire logic [31:0] status_view = status | (I_SRC_EVENT & `BIER_LEVEL_SRC);

   // =====================================================
   // routing to the two outputs
   wire logic [31:0] pending = status_view & enable_eff; // R25
   wire logic [31:0] to_pci = pending & route; // R24 R9
   wire logic [31:0] to_local = pending & ~route; // R24 R6 R7 R8
   wire logic next_pci_irq = |to_pci; // R27
   wire logic next_local_irq = |to_local; // R27

   // =====================================================
   // read decode
   wire logic r_idle = (rstate == bier_pkg::BIER_R_IDLE);
   wire logic rd_fire = r_idle && I_ARVALID;
   wire logic [11:0] rd_word = {I_ARADDR[11:2], 2'h0};
   wire logic hit_st_r = (rd_word == `BIER_OFF_STATUS);
   wire logic hit_en_r = (rd_word == `BIER_OFF_ENABLE); // R22
   wire logic hit_rt_r = (rd_word == `BIER_OFF_ROUTE);
   wire logic hit_s2_r = (rd_word == `BIER_OFF_SOFT2);
   wire logic hit_src_r = (rd_word == `BIER_OFF_SOURCE);
   wire logic rd_mapped = hit_st_r || hit_en_r || hit_rt_r || hit_s2_r || hit_src_r;
   wire logic [31:0] rd_mux = hit_st_r ? status_view
                            : hit_en_r ? enable_view
                            : hit_rt_r ? route
                            : hit_src_r ? I_SRC_EVENT
                            : 32'h0;

   assign O_ARREADY = r_idle;
   assign O_RVALID = (rstate == bier_pkg::BIER_R_DATA);
   assign O_RDATA = rdata;
   assign O_RRESP = rresp;

   // =====================================================
   // registers
   always_ff @(posedge I_SYS_CLK) begin
      if (I_SRST) begin
         enable <= `BIER_ENABLE_RST; // R26
      end else if (hit_en_w) begin
         enable <= next_enable_w; // R14 R15 R16 R17 R18
      end
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (I_SRST) begin
         route <= `BIER_ROUTE_RST;
      end else if (hit_rt_w) begin
         route <= next_route_w;
      end
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (I_SRST) begin
         status <= `BIER_STATUS_RST;
      end else begin
         status <= next_status;
      end
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (I_SRST) begin
         O_PCI_IRQ <= 1'b0;
         O_LOCAL_IRQ <= 1'b0;
      end else begin
         O_PCI_IRQ <= next_pci_irq;
         O_LOCAL_IRQ <= next_local_irq;
      end
   end

   // =====================================================
   // write handshake
   always_ff @(posedge I_SYS_CLK) begin
      if (I_SRST) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         wreq <= '0;
         wstate <= bier_pkg::BIER_W_IDLE;
         bresp <= `BIER_RESP_OKAY;
      end else begin
         if (wr_fire) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wstate <= bier_pkg::BIER_W_RESP;
            bresp <= wr_mapped ? `BIER_RESP_OKAY : `BIER_RESP_SLVERR;
         end else begin
            if (aw_take) begin
               aw_held <= 1'b1;
               wreq.addr <= I_AWADDR;
            end
            if (w_take) begin
               w_held <= 1'b1;
               wreq.data <= I_WDATA;
               wreq.strb <= I_WSTRB;
            end
            if (O_BVALID && I_BREADY) begin
               wstate <= bier_pkg::BIER_W_IDLE;
            end
         end
      end
   end

   // =====================================================
   // read handshake
   always_ff @(posedge I_SYS_CLK) begin
      if (I_SRST) begin
         rstate <= bier_pkg::BIER_R_IDLE;
         rdata <= 32'h0;
         rresp <= `BIER_RESP_OKAY;
      end else if (rd_fire) begin
         rstate <= bier_pkg::BIER_R_DATA;
         rdata <= rd_mux;
         rresp <= rd_mapped ? `BIER_RESP_OKAY : `BIER_RESP_SLVERR;
      end else if (O_RVALID && I_RREADY) begin
         rstate <= bier_pkg::BIER_R_IDLE;
      end
   end

endmodule

// *** testbench/bier_top_assertions.sv ***
// port assertions for the interrupt enable and routing block
// assumes it is bound onto every bier_top instance
`timescale 1ns/1ps
module bier_chk (
   // clock and reset
   input wire logic I_SYS_CLK,
   input wire logic I_SRST,
   // register bus
   input wire logic I_AWVALID,
   input wire logic O_AWREADY,
   input wire logic I_WVALID,
   input wire logic O_WREADY,
   input wire logic [1:0] O_BRESP,
   input wire logic O_BVALID,
   input wire logic I_BREADY,
   input wire logic [11:0] I_ARADDR,
   input wire logic I_ARVALID,
   input wire logic O_ARREADY,
   input wire logic [31:0] O_RDATA,
   input wire logic [1:0] O_RRESP,
   input wire logic O_RVALID,
   input wire logic I_RREADY,
   // interrupts
   input wire logic [31:0] I_SRC_EVENT,
   input wire logic I_OUTBOUND_POST_IRQ_MASK,
   input wire logic O_LOCAL_IRQ,
   input wire logic O_PCI_IRQ
);
   default clocking dc @(posedge I_SYS_CLK); endclocking
   default disable iff (I_SRST);
   a_irq_reset_low: assert property ($fell(I_SRST) |-> !O_LOCAL_IRQ && !O_PCI_IRQ)
      else $error("irq high after reset");
   a_bresp_hold: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
      else $error("write response dropped");
   a_write_answer: assert property (I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |=> O_BVALID && !O_AWREADY)
      else $error("no write response");
   a_rdata_hold: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
      else $error("read data dropped");
   a_read_answer: assert property (I_ARVALID && O_ARREADY |=> O_RVALID && !O_ARREADY)
      else $error("no read response");
   a_unmapped_read: assert property (I_ARVALID && O_ARREADY && (I_ARADDR[11:2] < 10'h180 ||
      I_ARADDR[11:2] > 10'h184) |=> O_RRESP == 2'h2 && O_RDATA == 32'h0) else $error("unmapped read");
   a_trigger_zero: assert property (I_ARVALID && O_ARREADY && I_ARADDR[11:2] == 10'h181 |=>
      O_RDATA[1:0] == 2'h0) else $error("trigger bits read nonzero");
   a_post_to_pci: assert property (I_SRC_EVENT[13] && I_OUTBOUND_POST_IRQ_MASK |-> ##[1:2] O_PCI_IRQ)
      else $error("post list irq missing");
endmodule
bind bier_top bier_chk i_chk (.*);

// *** testbench/bier_src_model.sv ***
// model of the interrupt sources around the block
// assumes the bench calls set once per clock edge
`timescale 1ns/1ps
module bier_src_model (
   // clock
   input wire logic i_clk,
   // source conditions and post list mask
   output logic [31:0] o_event,
   output logic o_post_mask
);
   initial begin
      o_event = 32'h0;
      o_post_mask = 1'b0;
   end
   task set(input logic [31:0] v, input logic m);
      @(posedge i_clk);
      o_event <= v;
      o_post_mask <= m;
   endtask
endmodule

// *** testbench/testbench.sv ***
// self-checking bench for the interrupt enable and routing block
// assumes bier_top, the source model and the checker are compiled first
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0, srst = 1'b1, awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
   logic [11:0] awaddr = 12'h0, araddr = 12'h0;
   logic [31:0] wdata = 32'h0, ev, rdata, rt;
   logic [3:0] strb = 4'hf;
   logic [1:0] bresp, rresp, wresp;
   logic awr, wrdy, bv, arr, rv, loc, pci, pmask;
   int mismatches = 0, checks = 0, cyc = 0;
   always #2 clk = ~clk;
   bier_src_model i_src (.i_clk(clk), .o_event(ev), .o_post_mask(pmask));
   bier_top i_dut (.I_SYS_CLK(clk), .I_SRST(srst), .I_AWADDR(awaddr), .I_AWVALID(awv), .O_AWREADY(awr),
      .I_WDATA(wdata), .I_WSTRB(strb), .I_WVALID(wv), .O_WREADY(wrdy), .O_BRESP(bresp), .O_BVALID(bv),
      .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arv), .O_ARREADY(arr), .O_RDATA(rdata),
      .O_RRESP(rresp), .O_RVALID(rv), .I_RREADY(rready), .I_SRC_EVENT(ev),
      .I_OUTBOUND_POST_IRQ_MASK(pmask), .O_LOCAL_IRQ(loc), .O_PCI_IRQ(pci));
   task chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         mismatches++;
         $display("mismatch at %0t: saw %h expected %h", $time, s, e);
      end
   endtask
   // handshakes are judged on settled values half a cycle before the edge
   task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      logic aw_go, w_go, b_go;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      strb <= s;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      do begin
         @(negedge clk);
         aw_go = awv && awr;
         w_go = wv && wrdy;
         b_go = bv;
         wresp = bresp;
         @(posedge clk);
         if (aw_go) awv <= 1'b0;
         if (w_go) wv <= 1'b0;
      end while (!b_go);
      bready <= 1'b0;
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
      logic ar_go, r_go;
      logic [31:0] got;
      logic [1:0] gresp;
      @(posedge clk);
      araddr <= a;
      arv <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge clk);
         ar_go = arv && arr;
         r_go = rv;
         got = rdata;
         gresp = rresp;
         @(posedge clk);
         if (ar_go) arv <= 1'b0;
      end while (!r_go);
      rready <= 1'b0;
      chk(got, e);
      chk({30'h0, gresp}, {30'h0, r});
   endtask
   // outputs settle two edges after an event
   task irq(input logic p, input logic l);
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk({30'h0, pci, loc}, {30'h0, p, l});
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         mismatches++;
         $display("mismatch at %0t: timeout", $time);
         summarize;
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      rd(12'h604, 32'h0, 2'h0);
      rd(12'h608, 32'h0010_2000, 2'h0);
      rd(12'h700, 32'h0, 2'h2);
      wr(12'h700, 32'h1, 4'hf);
      chk({30'h0, wresp}, {30'h0, 2'h2});
      wr(12'h608, 32'h0, 4'hf);
      chk({30'h0, wresp}, {30'h0, 2'h0});
      i_src.set(32'h8000_0000, 1'b0);
      i_src.set(32'h0, 1'b0);
      irq(1'b0, 1'b0);
      wr(12'h600, 32'hffff_ffff, 4'hf);
      $display("end reset");
      wr(12'h604, 32'hffff_ffff, 4'h8);
      rd(12'h604, 32'hff00_0000, 2'h0);
      wr(12'h604, 32'hffff_ffff, 4'hf);
      rd(12'h604, 32'hffff_df00, 2'h0);
      rd(12'h600, 32'h0000_0003, 2'h0);
      irq(1'b0, 1'b1);
      wr(12'h600, 32'h0000_0003, 4'hf);
      rd(12'h600, 32'h0, 2'h0);
      $display("end enables");
      for (int k = 0; k < 2; k++) begin
         wr(12'h608, k ? 32'hffff_ffff : 32'h0, 4'hf);
         rt = (k ? 32'hff0f_8f0f : 32'h0) | 32'h0010_2000;
         rd(12'h608, rt, 2'h0);
         for (int b = 31; b >= 12; b--) begin
            if (b != 13) begin
               i_src.set(32'h1 << b, 1'b0);
               i_src.set(32'h0, 1'b0);
               irq(rt[b], !rt[b]);
               wr(12'h600, 32'h1 << b, 4'hf);
               irq(1'b0, 1'b0);
            end
         end
      end
      $display("end routing");
      i_src.set(32'h0000_2000, 1'b1);
      irq(1'b1, 1'b0);
      rd(12'h604, 32'hffff_ff00, 2'h0);
      i_src.set(32'h0000_2000, 1'b0);
      irq(1'b0, 1'b0);
      i_src.set(32'h0, 1'b0);
      $display("end post list");
      summarize;
   end
endmodule
